// ===== hw/sas_defs.vh
// Constants for the serial audio slot transmit/receive control block.
// Assumes a 24-bit word register port and one 24-bit slot per word.
`ifndef SAS_DEFS_VH
`define SAS_DEFS_VH

// --------------------------------------------------------------
// Widths
// --------------------------------------------------------------
`define SAS_AW 24
`define SAS_DW 24
`define SAS_NTX 6
`define SAS_NRX 4
`define SAS_BIT_LAST 5'h17
`define SAS_SYNC_W 6

// --------------------------------------------------------------
// Register addresses
// --------------------------------------------------------------
`define SAS_A_TXW0 24'hffffa0
`define SAS_A_TXW5 24'hffffa5
`define SAS_A_NULL 24'hffffa6
`define SAS_A_STAT 24'hffffa7
`define SAS_A_RXW0 24'hffffa8
`define SAS_A_RXW3 24'hffffab
`define SAS_A_CTRL 24'hffffb4
`define SAS_A_IREN 24'hffffb5
`define SAS_A_PINS 24'hffffb6
`define SAS_A_TSM_LO 24'hffffb9
`define SAS_A_TSM_HI 24'h0fffba
`define SAS_A_RSM_LO 24'hffffbb
`define SAS_A_RSM_HI 24'hffffbc

// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define SAS_MASK_RST 16'hffff
`define SAS_CTRL_RST 20'h00000
`define SAS_PINS_RST 12'h000

// --------------------------------------------------------------
// Control register fields
// --------------------------------------------------------------
`define SAS_C_TEN_LO 0
`define SAS_C_REN_LO 6
`define SAS_C_NET 10
`define SAS_C_SYNC 11
`define SAS_C_EBE 12
`define SAS_C_RSD 13
`define SAS_C_ALC 14
`define SAS_C_SLOTS_LO 15

// --------------------------------------------------------------
// Interrupt enable / request bits (bit 7 highest priority)
// --------------------------------------------------------------
`define SAS_I_RX_EXC 7
`define SAS_I_RX_EVEN 6
`define SAS_I_RX_DATA 5
`define SAS_I_RX_LAST 4
`define SAS_I_TX_EXC 3
`define SAS_I_TX_LAST 2
`define SAS_I_TX_EVEN 1
`define SAS_I_TX_DATA 0

// --------------------------------------------------------------
// Status register bits
// --------------------------------------------------------------
`define SAS_S_TDE 0
`define SAS_S_TRANSMIT_EVEN_EMPTY_FLAG 1
`define SAS_S_TUE 2
`define SAS_S_RDF 3
`define SAS_S_RECEIVE_EVEN_FULL_FLAG 4
`define SAS_S_ROE 5
`define SAS_S_TXL 6
`define SAS_S_RXL 7
`define SAS_S_IRST 8

`endif

// ===== hw/sas_link_sync.v
// Input synchroniser and edge finder for the serial link pins.
// Assumes pins are asynchronous to sys_clk and change slowly vs it.
`include "sas_defs.vh"

module sas_link_sync (
	// Clock and reset
	input wire sys_clk,
	input wire nrst,
	// Raw pins
	input wire [`SAS_SYNC_W-1:0] pin_in,
	// Filtered levels and rising-edge pulses
	output reg [`SAS_SYNC_W-1:0] lvl_reg,
	output reg [`SAS_SYNC_W-1:0] rise_reg
);
	reg [`SAS_SYNC_W-1:0] s1_reg;
	reg [`SAS_SYNC_W-1:0] s2_reg;
	reg [`SAS_SYNC_W-1:0] s3_reg;
	wire [`SAS_SYNC_W-1:0] agree;

	// A change counts only once stages two and three agree
	assign agree = ~(s2_reg ^ s3_reg);

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s1_reg <= {`SAS_SYNC_W{1'b0}};
			s2_reg <= {`SAS_SYNC_W{1'b0}};
			s3_reg <= {`SAS_SYNC_W{1'b0}};
			lvl_reg <= {`SAS_SYNC_W{1'b0}};
			rise_reg <= {`SAS_SYNC_W{1'b0}};
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			lvl_reg <= (agree & s3_reg) | (~agree & lvl_reg);
			rise_reg <= agree & s3_reg & ~lvl_reg;
		end
	end
endmodule

// ===== hw/sas_top.v
// Slot-masked transmit/receive control of a multi-channel audio port.
// Assumes a plain register port on sys_clk and a bit clock far slower
// than sys_clk; all link inputs are sampled, not used as clocks.
`include "sas_defs.vh"

// What this block does
// - Six write-only 24-bit holding words feed shifters
// - Transmit request when holding words go empty
// - Null slot write tri-states data next slot
// - Receive sync pin disables buffers on null
// - Masked-off slot tri-states, loads; sets empty flag only if null pending
// - Enabled slot loads, transmits, sets empty flag
// - Null write honoured in enabled slots too
// - Transmit mask takes effect next frame; resets ones
// - Receive mask clear: shift, no transfer, no full/overrun flags
// - Receive mask next frame; resets ones; bit 0
// - Reset clears pin assignment; idle until assigned
// - Individual reset clears status, keeps control
// - Eight requests ranked, receive exception highest
// - Receive exception; overrun cleared by read sequence
// - Receive even and data requests; reads clear
// - Last-slot requests in network mode only
// - Transmit requests; underrun cleared by write sequence
// - Empty flag set on transfer, cleared by writes
module sas_top (
	// Clock and reset
	input wire sys_clk,
	input wire nrst,
	// Register port
	input wire [`SAS_AW-1:0] reg_addr,
	input wire [`SAS_DW-1:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [`SAS_DW-1:0] reg_rdata,
	// Serial link
	input wire bit_clk,
	input wire frame_sync,
	input wire [`SAS_NRX-1:0] rx_data,
	output reg [`SAS_NTX-1:0] tx_data_out,
	output reg [`SAS_NTX-1:0] tx_data_oe,
	output reg receive_frame_sync_pin_out,
	output reg receive_frame_sync_pin_oe,
	// Requests and state
	output reg [7:0] irq_req,
	output reg port_active
);
	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	function all_done;
		input [5:0] seen;
		input [5:0] en;
		begin
			all_done = ((seen & en) == en);
		end
	endfunction

	function [23:0] align_word;
		input [23:0] w;
		input alignment_select;
		begin
			align_word = alignment_select ? {w[15:0], 8'h00} : w;
		end
	endfunction

	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	reg [19:0] ctrl_reg;
	reg [7:0] iren_reg;
	reg [11:0] pins_reg;
	reg [15:0] tsm_lo_reg;
	reg [15:0] tsm_hi_reg;
	reg [15:0] rsm_lo_reg;
	reg [15:0] rsm_hi_reg;
	reg [31:0] tsm_cur_reg;
	reg [31:0] rsm_cur_reg;
	reg [23:0] hold_reg [0:5];
	reg [23:0] tsh_reg [0:5];
	reg [23:0] rsh_reg [0:3];
	reg [23:0] rxw_reg [0:3];
	reg [5:0] tx_seen_reg;
	reg [3:0] rx_seen_reg;
	reg null_pend_reg;
	reg slot_on_reg;
	reg in_frame_reg;
	reg [4:0] bit_reg;
	reg [4:0] slot_reg;
	reg tde_reg, transmit_even_empty_flag_reg, tue_reg, rdf_reg, receive_even_full_flag_reg, roe_reg;
	reg txl_reg, rxl_reg;
	reg tue_arm_reg, roe_arm_reg;
	reg [23:0] rd_value;
	reg [5:0] tx_hit;
	reg [3:0] rx_hit;
	reg [7:0] req;
	integer i;

	wire [`SAS_SYNC_W-1:0] lnk_lvl;
	wire [`SAS_SYNC_W-1:0] lnk_rise;

	sas_link_sync u_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.pin_in({rx_data, frame_sync, bit_clk}),
		.lvl_reg(lnk_lvl),
		.rise_reg(lnk_rise)
	);

	// --------------------------------------------------------------
	// Frame and slot timing
	// --------------------------------------------------------------
	wire [5:0] ten = ctrl_reg[`SAS_C_TEN_LO +: 6];
	wire [3:0] ren = ctrl_reg[`SAS_C_REN_LO +: 4];
	wire net = ctrl_reg[`SAS_C_NET];
	wire alignment_select = ctrl_reg[`SAS_C_ALC];
	wire active = |pins_reg;
	wire brise = lnk_rise[0] & active;
	wire fs_lvl = lnk_lvl[1];
	wire [4:0] last_slot = net ? ctrl_reg[`SAS_C_SLOTS_LO +: 5] : 5'h00;
	wire bit_end = (bit_reg == `SAS_BIT_LAST);
	wire frame_end = in_frame_reg & bit_end & (slot_reg == last_slot);
	// A new frame is only recognised once the previous one has finished
	wire frame_go = brise & fs_lvl & (~in_frame_reg | frame_end);
	wire slot_go = frame_go | (brise & in_frame_reg & bit_end & ~frame_end);
	wire [4:0] new_slot = frame_go ? 5'h00 : slot_reg + 5'h01;
	wire [31:0] tsm_use = frame_go ? {tsm_hi_reg, tsm_lo_reg} : tsm_cur_reg;
	wire tx_mbit = tsm_use[new_slot];
	wire slot_null = null_pend_reg;
	wire tx_flag_slot = slot_go & (tx_mbit | slot_null);
	wire rx_end = brise & in_frame_reg & bit_end;
	wire rx_mbit = rsm_cur_reg[slot_reg];
	wire null_wr = reg_wr & (reg_addr == `SAS_A_NULL);
	wire stat_rd = reg_rd & (reg_addr == `SAS_A_STAT);
	wire [5:0] tx_seen_now = tx_seen_reg | tx_hit;
	wire [3:0] rx_seen_now = rx_seen_reg | rx_hit;
	wire tx_all_wr = all_done(tx_seen_now, ten) | null_wr;
	wire rx_all_rd = all_done({2'b00, rx_seen_now}, {2'b00, ren});

	// --------------------------------------------------------------
	// Bus decode
	// --------------------------------------------------------------
	always @* begin
		tx_hit = 6'h00;
		rx_hit = 4'h0;
		rd_value = 24'h000000;
		for (i = 0; i < `SAS_NTX; i = i + 1) begin
			if (reg_wr && reg_addr == `SAS_A_TXW0 + i)
				tx_hit[i] = 1'b1;
		end
		for (i = 0; i < `SAS_NRX; i = i + 1) begin
			if (reg_rd && reg_addr == `SAS_A_RXW0 + i) begin
				rx_hit[i] = 1'b1;
				// Drop the alignment shift for right-justified reads
				rd_value = alignment_select ? {8'h00, rxw_reg[i][23:8]} : rxw_reg[i];
			end
		end
		case (reg_addr)
		`SAS_A_STAT: rd_value = {15'h0000, ~active, rxl_reg, txl_reg,
			roe_reg, receive_even_full_flag_reg, rdf_reg, tue_reg, transmit_even_empty_flag_reg, tde_reg};
		`SAS_A_CTRL: rd_value = {4'h0, ctrl_reg};
		`SAS_A_IREN: rd_value = {16'h0000, iren_reg};
		`SAS_A_PINS: rd_value = {12'h000, pins_reg};
		`SAS_A_TSM_LO: rd_value = {8'h00, tsm_lo_reg};
		`SAS_A_TSM_HI: rd_value = {8'h00, tsm_hi_reg};
		`SAS_A_RSM_LO: rd_value = {8'h00, rsm_lo_reg};
		`SAS_A_RSM_HI: rd_value = {8'h00, rsm_hi_reg};
		default: rd_value = rd_value;
		endcase
	end

	// --------------------------------------------------------------
	// Request ranking
	// --------------------------------------------------------------
	always @* begin
		req[`SAS_I_RX_EXC] = iren_reg[7] & rdf_reg & roe_reg;
		req[`SAS_I_RX_EVEN] = iren_reg[6] & rdf_reg & receive_even_full_flag_reg &
			~(roe_reg & iren_reg[7]);
		req[`SAS_I_RX_DATA] = iren_reg[5] & rdf_reg &
			~(roe_reg & iren_reg[7]) & ~(receive_even_full_flag_reg & iren_reg[6]);
		req[`SAS_I_RX_LAST] = iren_reg[4] & rxl_reg;
		req[`SAS_I_TX_EXC] = iren_reg[3] & tde_reg & tue_reg;
		req[`SAS_I_TX_LAST] = iren_reg[2] & txl_reg;
		req[`SAS_I_TX_EVEN] = iren_reg[1] & tde_reg & transmit_even_empty_flag_reg &
			~(tue_reg & iren_reg[3]);
		req[`SAS_I_TX_DATA] = iren_reg[0] & tde_reg &
			~(tue_reg & iren_reg[3]) & ~(transmit_even_empty_flag_reg & iren_reg[1]);
	end

	// --------------------------------------------------------------
	// Registers, flags and link engine
	// --------------------------------------------------------------
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 24'h000000;
			ctrl_reg <= `SAS_CTRL_RST;
			iren_reg <= 8'h00;
			pins_reg <= `SAS_PINS_RST;
			tsm_lo_reg <= `SAS_MASK_RST;
			tsm_hi_reg <= `SAS_MASK_RST;
			rsm_lo_reg <= `SAS_MASK_RST;
			rsm_hi_reg <= `SAS_MASK_RST;
			tsm_cur_reg <= {`SAS_MASK_RST, `SAS_MASK_RST};
			rsm_cur_reg <= {`SAS_MASK_RST, `SAS_MASK_RST};
			for (i = 0; i < `SAS_NTX; i = i + 1) begin
				hold_reg[i] <= 24'h000000;
				tsh_reg[i] <= 24'h000000;
			end
			for (i = 0; i < `SAS_NRX; i = i + 1) begin
				rsh_reg[i] <= 24'h000000;
				rxw_reg[i] <= 24'h000000;
			end
			tx_seen_reg <= 6'h00;
			rx_seen_reg <= 4'h0;
			null_pend_reg <= 1'b0;
			slot_on_reg <= 1'b0;
			in_frame_reg <= 1'b0;
			bit_reg <= 5'h00;
			slot_reg <= 5'h00;
			{tde_reg, transmit_even_empty_flag_reg, tue_reg} <= 3'h0;
			{rdf_reg, receive_even_full_flag_reg, roe_reg} <= 3'h0;
			{txl_reg, rxl_reg, tue_arm_reg, roe_arm_reg} <= 4'h0;
			tx_data_out <= 6'h00;
			tx_data_oe <= 6'h00;
			receive_frame_sync_pin_out <= 1'b0;
			receive_frame_sync_pin_oe <= 1'b0;
			irq_req <= 8'h00;
			port_active <= 1'b0;
		end else begin
			reg_rdata <= rd_value;
			port_active <= active;
			// Control writes; software keeps these stable while active
			if (reg_wr) begin
				case (reg_addr)
				`SAS_A_CTRL: ctrl_reg <= reg_wdata[19:0];
				`SAS_A_IREN: iren_reg <= reg_wdata[7:0];
				`SAS_A_PINS: pins_reg <= reg_wdata[11:0];
				`SAS_A_TSM_LO: tsm_lo_reg <= reg_wdata[15:0];
				`SAS_A_TSM_HI: tsm_hi_reg <= reg_wdata[15:0];
				`SAS_A_RSM_LO: rsm_lo_reg <= reg_wdata[15:0];
				`SAS_A_RSM_HI: rsm_hi_reg <= reg_wdata[15:0];
				default: ctrl_reg <= ctrl_reg;
				endcase
			end
			for (i = 0; i < `SAS_NTX; i = i + 1) begin
				if (tx_hit[i])
					hold_reg[i] <= align_word(reg_wdata, alignment_select);
			end
			if (null_wr)
				null_pend_reg <= 1'b1;

			// Software clears; hardware sets below win the same cycle
			if (stat_rd) begin
				tue_arm_reg <= tue_reg;
				roe_arm_reg <= roe_reg;
				txl_reg <= 1'b0;
				rxl_reg <= 1'b0;
			end
			tx_seen_reg <= tx_seen_now;
			rx_seen_reg <= rx_seen_now;
			if (tx_all_wr) begin
				tde_reg <= 1'b0;
				transmit_even_empty_flag_reg <= 1'b0;
				tx_seen_reg <= 6'h00;
				if (tue_arm_reg) begin
					tue_reg <= 1'b0;
					tue_arm_reg <= 1'b0;
				end
			end
			if (rx_all_rd && |ren) begin
				rdf_reg <= 1'b0;
				receive_even_full_flag_reg <= 1'b0;
				rx_seen_reg <= 4'h0;
				if (roe_arm_reg) begin
					roe_reg <= 1'b0;
					roe_arm_reg <= 1'b0;
				end
			end

			// Bit engine: one bit per bit clock rise
			if (brise && in_frame_reg) begin
				for (i = 0; i < `SAS_NRX; i = i + 1)
					rsh_reg[i] <= {rsh_reg[i][22:0], lnk_lvl[2 + i]};
				for (i = 0; i < `SAS_NTX; i = i + 1)
					tsh_reg[i] <= {tsh_reg[i][22:0], 1'b0};
				if (bit_end) begin
					bit_reg <= 5'h00;
					slot_reg <= slot_reg + 5'h01;
				end else begin
					bit_reg <= bit_reg + 5'h01;
				end
				if (frame_end) begin
					in_frame_reg <= 1'b0;
					slot_on_reg <= 1'b0;
				end
			end

			// Receive transfer at the end of each slot whose receive mask bit is set
			if (rx_end && rx_mbit) begin
				for (i = 0; i < `SAS_NRX; i = i + 1) begin
					if (ren[i])
						rxw_reg[i] <= {rsh_reg[i][22:0], lnk_lvl[2 + i]};
				end
				if (|ren) begin
					if (rdf_reg)
						roe_reg <= 1'b1;
					rdf_reg <= 1'b1;
					receive_even_full_flag_reg <= ~slot_reg[0];
				end
			end
			if (rx_end && frame_end && net)
				rxl_reg <= 1'b1;

			// Slot start: load shifters, set empty and underrun flags
			if (frame_go) begin
				in_frame_reg <= 1'b1;
				tsm_cur_reg <= {tsm_hi_reg, tsm_lo_reg};
				rsm_cur_reg <= {rsm_hi_reg, rsm_lo_reg};
			end
			if (slot_go) begin
				bit_reg <= 5'h00;
				slot_reg <= new_slot;
				// Shifters always reload, even in masked-off slots
				for (i = 0; i < `SAS_NTX; i = i + 1)
					tsh_reg[i] <= hold_reg[i];
				slot_on_reg <= tx_mbit & ~slot_null;
				null_pend_reg <= null_wr;
				if (tx_flag_slot && |ten) begin
					tde_reg <= 1'b1;
					transmit_even_empty_flag_reg <= ~new_slot[0];
					tx_seen_reg <= tx_hit;
					// Unwritten words go out again as old data
					// Still empty from the last slot: nothing new written
					if (tx_mbit && !slot_null && tde_reg)
						tue_reg <= 1'b1;
				end
				if (net && new_slot == last_slot)
					txl_reg <= 1'b1;
			end

			// Individual reset: status and link cleared, control kept
			if (!active) begin
				{tde_reg, transmit_even_empty_flag_reg, tue_reg} <= 3'h0;
				{rdf_reg, receive_even_full_flag_reg, roe_reg} <= 3'h0;
				{txl_reg, rxl_reg, tue_arm_reg, roe_arm_reg} <= 4'h0;
				in_frame_reg <= 1'b0;
				slot_on_reg <= 1'b0;
				null_pend_reg <= 1'b0;
				tx_seen_reg <= 6'h00;
				rx_seen_reg <= 4'h0;
				bit_reg <= 5'h00;
				slot_reg <= 5'h00;
			end

			// Pins follow the shifters one cycle later
			for (i = 0; i < `SAS_NTX; i = i + 1)
				tx_data_out[i] <= tsh_reg[i][23];
			tx_data_oe <= ten & {6{slot_on_reg & in_frame_reg & active}};
			// Low on the pin holds the external buffers off
			receive_frame_sync_pin_out <= slot_on_reg & in_frame_reg;
			receive_frame_sync_pin_oe <= active & ctrl_reg[`SAS_C_SYNC] &
				ctrl_reg[`SAS_C_EBE] & ctrl_reg[`SAS_C_RSD];
			// One-hot of the highest pending request
			irq_req <= 8'h00;
			casez (req)
			8'b1???????: irq_req <= 8'h80;
			8'b01??????: irq_req <= 8'h40;
			8'b001?????: irq_req <= 8'h20;
			8'b0001????: irq_req <= 8'h10;
			8'b00001???: irq_req <= 8'h08;
			8'b000001??: irq_req <= 8'h04;
			8'b0000001?: irq_req <= 8'h02;
			8'b00000001: irq_req <= 8'h01;
			default: irq_req <= 8'h00;
			endcase
		end
	end
endmodule

// ===== test/sas_top_monitor.sv
// Port-level assertions for the slot control block.
// Assumes it is bound into sas_top; one clock, async active-low reset.
`include "sas_defs.vh"

module sas_top_monitor (
	// Clock and reset
	input logic sys_clk,
	input logic nrst,
	// Register port
	input logic [`SAS_AW-1:0] reg_addr,
	input logic [`SAS_DW-1:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	input logic [`SAS_DW-1:0] reg_rdata,
	// Serial link
	input logic bit_clk,
	input logic frame_sync,
	input logic [`SAS_NRX-1:0] rx_data,
	input logic [`SAS_NTX-1:0] tx_data_out,
	input logic [`SAS_NTX-1:0] tx_data_oe,
	input logic receive_frame_sync_pin_out,
	input logic receive_frame_sync_pin_oe,
	// Requests and state
	input logic [7:0] irq_req,
	input logic port_active
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	sequence s_tsm_wr_rd;
		reg_wr && reg_addr == `SAS_A_TSM_LO ##2
		reg_rd && reg_addr == `SAS_A_TSM_LO;
	endsequence
	sequence s_rsm_wr_rd;
		reg_wr && reg_addr == `SAS_A_RSM_HI ##2
		reg_rd && reg_addr == `SAS_A_RSM_HI;
	endsequence
	// Reserved upper byte must read as zero
	property p_tsm_back;
		s_tsm_wr_rd |=> reg_rdata == {8'h00, $past(reg_wdata[15:0], 3)};
	endproperty
	a_tsm_back: assert property (p_tsm_back)
		else $error("tx mask readback differs");
	property p_rsm_back;
		s_rsm_wr_rd |=> reg_rdata == {8'h00, $past(reg_wdata[15:0], 3)};
	endproperty
	a_rsm_back: assert property (p_rsm_back)
		else $error("rx mask readback differs");
	property p_wo_zero;
		reg_rd && reg_addr >= `SAS_A_TXW0 && reg_addr <= `SAS_A_NULL
		|=> reg_rdata == 24'h000000;
	endproperty
	a_wo_zero: assert property (p_wo_zero)
		else $error("write-only word read nonzero");

	// ----------------------------------------
	// Link and requests
	// ----------------------------------------
	property p_onehot;
		$onehot0(irq_req);
	endproperty
	a_onehot: assert property (p_onehot)
		else $error("more than one request shown");
	property p_idle;
		!port_active [*3] |-> tx_data_oe == 6'h00 && irq_req == 8'h00;
	endproperty
	a_idle: assert property (p_idle)
		else $error("activity during individual reset");
	// Outputs move only a few cycles after a bit clock rise
	property p_oe_bclk;
		$changed(tx_data_oe) && $past(port_active) && port_active
		|-> $past(bit_clk, 2);
	endproperty
	a_oe_bclk: assert property (p_oe_bclk)
		else $error("enable moved outside a bit clock rise");
	property p_data_bclk;
		$changed(tx_data_out) && $past(port_active) && port_active
		|-> $past(bit_clk, 2);
	endproperty
	a_data_bclk: assert property (p_data_bclk)
		else $error("data moved outside a bit clock rise");
	property p_buf_pin;
		$rose(receive_frame_sync_pin_oe) |-> port_active;
	endproperty
	a_buf_pin: assert property (p_buf_pin)
		else $error("buffer pin driven while idle");
endmodule

bind sas_top sas_top_monitor mon (.sys_clk(sys_clk), .nrst(nrst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_clk(bit_clk),
	.frame_sync(frame_sync), .rx_data(rx_data),
	.tx_data_out(tx_data_out), .tx_data_oe(tx_data_oe),
	.receive_frame_sync_pin_out(receive_frame_sync_pin_out),
	.receive_frame_sync_pin_oe(receive_frame_sync_pin_oe),
	.irq_req(irq_req), .port_active(port_active));

// ===== test/sas_codec_model.sv
// Behavioural codec on the far side of the serial link.
// Assumes bit-long frame sync, MSB first, 24-bit slots, 160 ns bits.
module sas_codec_model (
	// Toward the port
	output logic bit_clk,
	output logic frame_sync,
	output logic [3:0] rx_data,
	// From the port
	input logic [5:0] tx_out,
	input logic [5:0] tx_oe,
	input logic buf_en
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [23:0] rx_word [0:3];
	logic [23:0] cap_word [0:3];
	logic [3:0] cap_on;
	logic [3:0] cap_buf;

	initial begin
		bit_clk = 1'b0;
		frame_sync = 1'b0;
		rx_data = 4'h0;
	end

	// Clock runs only inside frames; sync is one bit ahead of slot 0
	task automatic frame(input int n);
		int s;
		cap_on = 4'h0;
		cap_buf = 4'h0;
		for (int i = -1; i < n * 24; i++) begin
			s = (i < 0) ? 0 : i / 24;
			frame_sync = (i < 0);
			rx_data = (i < 0) ? ~rx_data : {4{rx_word[s][23 - i % 24]}};
			#80 bit_clk = 1'b1;
			if (i >= 0) begin
				if (i % 24 == 0) begin
					cap_on[s] = 1'b1;
					cap_buf[s] = 1'b1;
				end
				cap_word[s] = {cap_word[s][22:0], tx_out[0]};
				cap_on[s] = cap_on[s] & tx_oe[0];
				cap_buf[s] = cap_buf[s] & buf_en;
			end
			#80 bit_clk = 1'b0;
		end
		frame_sync = 1'b0;
		// No pull on the data lines: show the inverse once released
		rx_data = ~rx_data;
	endtask
endmodule

// ===== test/sas_top_test.sv
// Self-checking bench for the slot control block.
// Assumes sas_top, the codec model and the port monitor are compiled.
`include "sas_defs.vh"

module sas_top_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [23:0] reg_addr = 24'h000000;
	logic [23:0] reg_wdata = 24'h000000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [23:0] reg_rdata;
	logic [23:0] d;
	wire bit_clk, frame_sync, buf_out, buf_oe, port_active;
	wire [3:0] rx_data;
	wire [5:0] tx_data_out, tx_data_oe;
	wire [7:0] irq_req;
	int fails = 0;
	int compares = 0;

	always #5 sys_clk = ~sys_clk;

	sas_top dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .bit_clk(bit_clk), .frame_sync(frame_sync),
		.rx_data(rx_data), .tx_data_out(tx_data_out),
		.tx_data_oe(tx_data_oe), .receive_frame_sync_pin_out(buf_out),
		.receive_frame_sync_pin_oe(buf_oe), .irq_req(irq_req),
		.port_active(port_active));
	sas_codec_model codec (.bit_clk(bit_clk), .frame_sync(frame_sync),
		.rx_data(rx_data), .tx_out(tx_data_out), .tx_oe(tx_data_oe),
		.buf_en(buf_out));

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic wr(input logic [23:0] a, input logic [23:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [23:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Bounded wait; running out ends the run
	task automatic wait_irq(input logic [7:0] exp);
		for (int n = 0; n < 40 && irq_req !== exp; n++) begin
			@(posedge sys_clk);
			#1;
		end
		compares++;
		if (irq_req !== exp) begin
			fails++;
			$display("unexpected at %0t: request %h", $time, irq_req);
			finish_test;
		end
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rd(`SAS_A_TSM_LO); chk(d, 24'h00ffff);
		rd(`SAS_A_RSM_HI); chk(d, 24'h00ffff);
		rd(`SAS_A_TXW5); chk(d, 24'h000000);
		rd(24'h000000); chk(d, 24'h000000);
		rd(`SAS_A_STAT); chk(d, 24'h000100);
		chk({23'h0, port_active}, 24'h000000);
		wr(`SAS_A_TSM_LO, 24'hffa5a5);
		rd(`SAS_A_TSM_LO); chk(d, 24'h00a5a5);
		wr(`SAS_A_RSM_HI, 24'hff5a5a);
		rd(`SAS_A_RSM_HI); chk(d, 24'h005a5a);
		wr(`SAS_A_TSM_LO, 24'h00ffff);
		wr(`SAS_A_RSM_HI, 24'h00ffff);
		$display("test reset done");
	endtask

	task automatic t_normal;
		wr(`SAS_A_CTRL, 24'h000041);
		wr(`SAS_A_IREN, 24'h000021);
		wr(`SAS_A_TXW0, 24'h123456);
		wr(`SAS_A_PINS, 24'h000001);
		codec.rx_word[0] = 24'hc3a55a;
		codec.frame(1);
		chk(codec.cap_word[0], 24'h123456);
		chk({23'h0, codec.cap_on[0]}, 24'h000001);
		wait_irq(8'h20);
		rd(`SAS_A_RXW0); chk(d, 24'hc3a55a);
		wait_irq(8'h01);
		wr(`SAS_A_PINS, 24'h000000);
		wait_irq(8'h00);
		rd(`SAS_A_STAT); chk(d, 24'h000100);
		rd(`SAS_A_CTRL); chk(d, 24'h000041);
		$display("test normal done");
	endtask

	task automatic t_network;
		wr(`SAS_A_IREN, 24'h000000);
		wr(`SAS_A_CTRL, 24'h01bc41);
		wr(`SAS_A_TSM_LO, 24'h000005);
		wr(`SAS_A_TSM_HI, 24'h000000);
		wr(`SAS_A_RSM_LO, 24'h000001);
		wr(`SAS_A_RSM_HI, 24'h000000);
		wr(`SAS_A_TXW0, 24'habcdef);
		wr(`SAS_A_PINS, 24'h000001);
		for (int i = 0; i < 4; i++)
			codec.rx_word[i] = 24'h3c1e0f ^ (24'h111111 * i);
		// New mask written in slot 1 must wait for the next frame
		fork
			codec.frame(4);
			begin
				#4800;
				wr(`SAS_A_TSM_LO, 24'h000003);
			end
		join
		chk(codec.cap_word[0], 24'habcdef);
		chk({20'h0, codec.cap_on}, 24'h000005);
		rd(`SAS_A_RXW0); chk(d, codec.rx_word[0]);
		rd(`SAS_A_STAT); chk({23'h0, d[`SAS_S_TUE]}, 24'h000001);
		wr(`SAS_A_TXW0, 24'h0f0f0f);
		rd(`SAS_A_STAT); chk({23'h0, d[`SAS_S_TUE]}, 24'h000000);
		// Null write inside slot 0 silences slot 1
		fork
			codec.frame(4);
			begin
				#960;
				wr(`SAS_A_NULL, 24'h000000);
			end
		join
		chk(codec.cap_word[0], 24'h0f0f0f);
		chk({20'h0, codec.cap_on}, 24'h000001);
		chk({22'h0, codec.cap_buf[1:0]}, 24'h000001);
		chk({23'h0, buf_oe}, 24'h000001);
		$display("test network done");
	endtask

	initial begin
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		t_reset;
		t_normal;
		t_network;
		finish_test;
	end
endmodule
